// *** src/rx_status_pkg.sv ***
/*
  Constants for the receive alarm, status and test-port register block:
  register offsets, field positions, reset values and detector counts.
  Assumes an 8-bit register port and one 25 MHz clock.
*/
package rx_status_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] ADDR_SPARE_LEN = 8'h89;
  localparam logic [7:0] ADDR_TP_CTRL = 8'h8A;
  localparam logic [7:0] ADDR_TP_SUPPRESS = 8'h8B;
  localparam logic [7:0] ADDR_ALARM = 8'h90;
  localparam logic [7:0] ADDR_EVENT = 8'h91;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] RESET_SPARE = 3'h0;
  localparam logic [2:0] RESET_TP_CTRL = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // test-port control fields
  localparam int TP_ENABLE = 0;
  localparam int TP_FRAMED = 1;
  localparam int TP_DIRECTION = 2;

  // spare code length select
  localparam logic [2:0] SPARE_LONG_CODE = 3'h7;
  localparam logic [3:0] SPARE_LONG_LEN = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // alarm condition order; detect flags low nibble, clear flags high
  localparam int COND_FRAME_LOSS = 0;
  localparam int COND_SIGNAL_LOSS = 1;
  localparam int COND_ALL_ONES = 2;
  localparam int COND_REMOTE_ALARM = 3;

  // t1 event positions
  localparam int T1_FRAMING_BIT_ERR = 0;
  localparam int T1_B8ZS_CODEWORD = 1;
  localparam int T1_SEVERE_FRAMING = 2;
  localparam int T1_ZERO_RUN_16 = 3;
  localparam int T1_ZERO_RUN_8 = 4;
  localparam int T1_ALIGN_CHANGE = 5;
  localparam int T1_PULSE_DENSITY = 7;

  // e1 event positions
  localparam int E1_ALIGN_FRAME = 0;
  localparam int E1_CRC_MF = 1;
  localparam int E1_SIG_ALL_ZEROS = 2;
  localparam int E1_SIG_ALL_ONES = 3;
  localparam int E1_FAS_RESYNC = 4;
  localparam int E1_MFA_RESYNC = 5;
  localparam int E1_CRC_RESYNC = 6;
  localparam logic [7:0] E1_PENDING_MASK = 8'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // detector counts
  localparam logic [7:0] LOS_ZERO_COUNT = 8'd192;
  localparam logic [7:0] ZERO_RUN_SHORT = 8'd8;
  localparam logic [7:0] ZERO_RUN_LONG = 8'd16;
  localparam logic [11:0] AIS_ONES_COUNT = 12'd2048;
  localparam logic [3:0] SEVERE_FRAMING_ERROR_FLAG_ERR_COUNT = 4'd2;
  localparam logic [9:0] CRC_WINDOW = 10'd1000;
  localparam logic [9:0] CRC_ERR_LIMIT = 10'd915;
  localparam logic [1:0] MFA_ERR_RUN = 2'd2;
  localparam logic [1:0] FAS_ERR_RUN = 2'd3;
  localparam logic [3:0] TS16_LAST_FRAME = 4'd15;
  localparam logic [7:0] TS16_MIN_ZEROS = 8'd3;

endpackage : rx_status_pkg

// *** src/rx_line_if.sv ***
/*
  Carrier between the port block and its line monitor: synchronised line
  symbols in, run and code detections out. Both ends share mclk.
*/
`timescale 1ns/1ps
interface rx_line_if;
  logic tick;
  logic pos;
  logic neg;
  logic zero8_evt;
  logic zero16_evt;
  logic los_cond;
  logic ais_cond;
  logic b8zs_evt;

  modport src (
    output tick, pos, neg,
    input zero8_evt, zero16_evt, los_cond, ais_cond, b8zs_evt
  );
  modport mon (
    input tick, pos, neg,
    output zero8_evt, zero16_evt, los_cond, ais_cond, b8zs_evt
  );
endinterface : rx_line_if

// *** src/flag_latch.sv ***
/*
  Bank of sticky flags: hardware sets, software clears by mask.
  Assumes set and clear masks are one-cycle pulses on mclk.
*/
`timescale 1ns/1ps
module flag_latch
  import rx_status_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // set and clear
  input wire logic [WIDTH-1:0] set_evt,
  input wire logic [WIDTH-1:0] clr_mask,
  output logic [WIDTH-1:0] flags
);

  // set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr_mask) | set_evt;
    end
  end

endmodule : flag_latch

// *** src/line_monitor.sv ***
/*
  Watches synchronised bipolar line symbols for zero runs, loss of signal,
  all-ones and the B8ZS substitution codeword.
  Assumes tick marks one symbol period on mclk.
*/
`timescale 1ns/1ps
module line_monitor
  import rx_status_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // line symbols and detections
  rx_line_if.mon line
);

  logic mark;
  logic [7:0] zrun;
  logic [11:0] orun;
  logic [15:0] sym;
  logic [15:0] next_sym;
  logic [1:0] pol_before;
  logic [1:0] pol_last;
  logic [1:0] pol_inv;

  assign mark = line.pos | line.neg;
  assign next_sym = {sym[13:0], line.pos, line.neg};
  // the symbol leaving the window this tick is the nearest one before it
  assign pol_last = (sym[15:14] != 2'b00) ? sym[15:14] : pol_before;
  assign pol_inv = {pol_last[0], pol_last[1]};

  ////////////////////////////////////////////////////////////////////////////
  // zero runs and loss of signal
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      zrun <= 8'h00;
      line.zero8_evt <= 1'b0;
      line.zero16_evt <= 1'b0;
      line.los_cond <= 1'b0;
    end else begin
      line.zero8_evt <= line.tick & ~mark & (zrun == ZERO_RUN_SHORT - 8'd1);
      line.zero16_evt <= line.tick & ~mark & (zrun == ZERO_RUN_LONG - 8'd1);
      if (line.tick) begin
        if (mark) begin
          zrun <= 8'h00;
          line.los_cond <= 1'b0;
        end else begin
          if (zrun != 8'hFF) begin
            zrun <= zrun + 8'd1;
          end
          if (zrun == LOS_ZERO_COUNT - 8'd1) begin
            line.los_cond <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unframed all-ones: a long unbroken run of marks
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      orun <= 12'h000;
      line.ais_cond <= 1'b0;
    end else if (line.tick) begin
      if (!mark) begin
        orun <= 12'h000;
        line.ais_cond <= 1'b0;
      end else if (orun != AIS_ONES_COUNT) begin
        orun <= orun + 12'd1;
      end else begin
        line.ais_cond <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 000VB0VB against the last mark before the window, any coding mode
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sym <= 16'h0000;
      pol_before <= 2'b00;
      line.b8zs_evt <= 1'b0;
    end else begin
      line.b8zs_evt <= line.tick & (pol_last != 2'b00) &
        (next_sym == {6'h00, pol_last, pol_inv, 2'b00, pol_inv,
        pol_last});
      if (line.tick) begin
        sym <= next_sym;
        if (sym[15:14] != 2'b00) begin
          pol_before <= sym[15:14];
        end
      end
    end
  end

endmodule : line_monitor

// *** src/rx_alarm_port.sv ***
/*
  Receive-side control and latched status of one port: spare code length,
  test-pattern port routing and suppression, latched alarm and event flags.
  Assumes framer inputs are on mclk; line pins are asynchronous.
*/
`timescale 1ns/1ps

module rx_alarm_port
  import rx_status_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // mode
  input wire logic e1_mode,
  // line pins and symbol tick
  input wire logic line_in_pos,
  input wire logic line_in_neg,
  input wire logic line_bit_tick,
  // framer conditions and events
  input wire logic remote_alarm,
  input wire logic frame_sync_lost,
  input wire logic resync_done,
  input wire logic [3:0] resync_alignment,
  input wire logic framing_bit_strobe,
  input wire logic framing_bit_err,
  input wire logic crc_word_strobe,
  input wire logic crc_word_err,
  input wire logic mfa_word_strobe,
  input wire logic mfa_word_err,
  input wire logic fas_word_strobe,
  input wire logic fas_word_err,
  input wire logic ts16_strobe,
  input wire logic [7:0] ts16_byte,
  input wire logic mf_start,
  input wire logic crc_mf_boundary,
  input wire logic align_frame_event,
  // pattern tester sources
  input wire logic framer_bit,
  input wire logic framer_bit_valid,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic f_bit_slot,
  input wire logic [2:0] chan_bit_index,
  // outputs
  output logic bert_bit,
  output logic bert_bit_valid,
  output logic [3:0] spare_len_bits,
  output logic spare_len_ext,
  output logic status_event_pending
);

  function automatic logic [3:0] count_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'b000, v[i]};
    end
    return n;
  endfunction : count_ones

  ////////////////////////////////////////////////////////////////////////////
  // line pin synchronisers
  logic pos_meta;
  logic pos_sync;
  logic neg_meta;
  logic neg_sync;
  rx_line_if line ();

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pos_meta <= 1'b0;
      pos_sync <= 1'b0;
      neg_meta <= 1'b0;
      neg_sync <= 1'b0;
    end else begin
      pos_meta <= line_in_pos;
      pos_sync <= pos_meta;
      neg_meta <= line_in_neg;
      neg_sync <= neg_meta;
    end
  end

  assign line.tick = line_bit_tick;
  assign line.pos = pos_sync;
  assign line.neg = neg_sync;

  line_monitor u_line_monitor (
    .mclk (mclk),
    .nrst (nrst),
    .line (line.mon)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [2:0] spare_code_length_sel;
  logic [2:0] tp_ctrl;
  logic [7:0] channel_bit_suppress;
  logic test_port_enable;
  logic test_port_framed_sel;
  logic test_port_direction;

  assign test_port_enable = tp_ctrl[TP_ENABLE];
  assign test_port_framed_sel = tp_ctrl[TP_FRAMED];
  assign test_port_direction = tp_ctrl[TP_DIRECTION];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      spare_code_length_sel <= RESET_SPARE;
      tp_ctrl <= RESET_TP_CTRL;
      channel_bit_suppress <= RESET_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_SPARE_LEN) begin
        spare_code_length_sel <= reg_wdata[2:0];
      end
      if (reg_addr == ADDR_TP_CTRL) begin
        tp_ctrl <= reg_wdata[2:0];
      end
      if (reg_addr == ADDR_TP_SUPPRESS) begin
        channel_bit_suppress <= reg_wdata;
      end
    end
  end

  // spare code length handed to the matcher
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      spare_len_bits <= 4'h1;
      spare_len_ext <= 1'b0;
    end else if (spare_code_length_sel == SPARE_LONG_CODE) begin
      spare_len_bits <= SPARE_LONG_LEN;
      spare_len_ext <= 1'b1;
    end else begin
      spare_len_bits <= {1'b0, spare_code_length_sel} + 4'h1;
      spare_len_ext <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern tester routing
  logic src_bit;
  logic src_valid;
  logic drop_fbit;
  logic drop_chan;

  // transmit data is taken before the elastic store, so it needs no ES path
  assign src_bit = test_port_direction ? tx_bit : framer_bit;
  assign src_valid = test_port_direction ? tx_bit_valid : framer_bit_valid;
  // e1 has no F-bit, so the slot marker never drops a bit there
  assign drop_fbit = f_bit_slot & ~e1_mode & ~test_port_framed_sel;
  assign drop_chan = ~f_bit_slot & channel_bit_suppress[chan_bit_index];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bert_bit <= 1'b0;
      bert_bit_valid <= 1'b0;
    end else begin
      bert_bit <= src_bit;
      bert_bit_valid <= test_port_enable & src_valid & ~drop_fbit &
        ~drop_chan;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarm conditions and their edges
  logic [3:0] cond_now;
  logic [3:0] cond_prev;
  logic [7:0] alarm_set;
  logic [7:0] alarm_clr;
  logic [7:0] alarm_flags;

  always_comb begin
    cond_now = 4'h0;
    cond_now[COND_FRAME_LOSS] = frame_sync_lost;
    cond_now[COND_SIGNAL_LOSS] = line.los_cond;
    cond_now[COND_ALL_ONES] = line.ais_cond;
    cond_now[COND_REMOTE_ALARM] = remote_alarm;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cond_prev <= 4'h0;
    end else begin
      cond_prev <= cond_now;
    end
  end

  assign alarm_set = {~cond_now & cond_prev, cond_now & ~cond_prev};
  assign alarm_clr = (reg_wr && reg_addr == ADDR_ALARM) ? reg_wdata : 8'h00;

  flag_latch #(.WIDTH(8)) u_alarm_flags (
    .mclk (mclk),
    .nrst (nrst),
    .set_evt (alarm_set),
    .clr_mask (alarm_clr),
    .flags (alarm_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // t1 framing history and alignment
  logic [5:0] fbit_hist;
  logic [5:0] next_fbit_hist;
  logic severe_framing_error_flag_evt;
  logic [3:0] held_alignment;
  logic alignment_known;
  logic alignment_change_flag_evt;

  assign next_fbit_hist = {fbit_hist[4:0], framing_bit_err};

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fbit_hist <= 6'h00;
      severe_framing_error_flag_evt <= 1'b0;
    end else begin
      severe_framing_error_flag_evt <= framing_bit_strobe & framing_bit_err &
        (count_ones({2'b00, next_fbit_hist}) >= SEVERE_FRAMING_ERROR_FLAG_ERR_COUNT);
      if (framing_bit_strobe) begin
        fbit_hist <= next_fbit_hist;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      held_alignment <= 4'h0;
      alignment_known <= 1'b0;
      alignment_change_flag_evt <= 1'b0;
    end else begin
      alignment_change_flag_evt <= resync_done & alignment_known &
        (resync_alignment != held_alignment);
      if (resync_done) begin
        held_alignment <= resync_alignment;
        alignment_known <= 1'b1;
      end
    end
  end

  logic [7:0] t1_set;
  logic [7:0] t1_flags;

  always_comb begin
    t1_set = 8'h00;
    if (!e1_mode) begin
      t1_set[T1_FRAMING_BIT_ERR] = framing_bit_strobe & framing_bit_err;
      t1_set[T1_B8ZS_CODEWORD] = line.b8zs_evt;
      t1_set[T1_SEVERE_FRAMING] = severe_framing_error_flag_evt;
      t1_set[T1_ZERO_RUN_16] = line.zero16_evt;
      t1_set[T1_ZERO_RUN_8] = line.zero8_evt;
      t1_set[T1_ALIGN_CHANGE] = alignment_change_flag_evt;
      // density judged by the 16-zero run only
      t1_set[T1_PULSE_DENSITY] = line.zero16_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // e1 resync criteria
  logic [9:0] crc_words;
  logic [9:0] crc_errs;
  logic crc_evt;
  logic [1:0] mfa_run;
  logic [1:0] fas_run;
  logic mfa_evt;
  logic fas_evt;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      crc_words <= 10'h000;
      crc_errs <= 10'h000;
      crc_evt <= 1'b0;
    end else begin
      crc_evt <= 1'b0;
      if (crc_word_strobe) begin
        if (crc_words == CRC_WINDOW - 10'd1) begin
          crc_evt <= (crc_errs + {9'h000, crc_word_err}) >= CRC_ERR_LIMIT;
          crc_words <= 10'h000;
          crc_errs <= 10'h000;
        end else begin
          crc_words <= crc_words + 10'd1;
          crc_errs <= crc_errs + {9'h000, crc_word_err};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mfa_run <= 2'h0;
      mfa_evt <= 1'b0;
    end else begin
      mfa_evt <= mfa_word_strobe & mfa_word_err &
        (mfa_run == MFA_ERR_RUN - 2'd1);
      if (mfa_word_strobe) begin
        if (!mfa_word_err || mfa_run == MFA_ERR_RUN - 2'd1) begin
          mfa_run <= 2'h0;
        end else begin
          mfa_run <= mfa_run + 2'd1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fas_run <= 2'h0;
      fas_evt <= 1'b0;
    end else begin
      fas_evt <= fas_word_strobe & fas_word_err &
        (fas_run == FAS_ERR_RUN - 2'd1);
      if (fas_word_strobe) begin
        if (!fas_word_err || fas_run == FAS_ERR_RUN - 2'd1) begin
          fas_run <= 2'h0;
        end else begin
          fas_run <= fas_run + 2'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeslot 16 over one 16-frame block, aligned by mf_start
  logic [3:0] ts16_frame;
  logic [3:0] frame_now;
  logic [7:0] ts16_zeros;
  logic [7:0] zeros_now;
  logic [7:0] next_zeros;
  logic ts16_all_zero;
  logic ts16_aligned;
  logic sa1_evt;
  logic sa0_evt;

  assign frame_now = mf_start ? 4'h0 : ts16_frame;
  assign zeros_now = 8'd8 - {4'h0, count_ones(ts16_byte)};
  assign next_zeros = (mf_start ? 8'h00 : ts16_zeros) + zeros_now;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ts16_frame <= 4'h0;
      ts16_zeros <= 8'h00;
      ts16_all_zero <= 1'b1;
      ts16_aligned <= 1'b0;
      sa1_evt <= 1'b0;
      sa0_evt <= 1'b0;
    end else begin
      sa1_evt <= 1'b0;
      sa0_evt <= 1'b0;
      if (ts16_strobe) begin
        if (frame_now == TS16_LAST_FRAME) begin
          // signalling mode does not gate this check
          sa1_evt <= next_zeros < TS16_MIN_ZEROS;
          sa0_evt <= ts16_aligned & (ts16_byte == 8'h00) &
            ts16_all_zero;
          ts16_frame <= 4'h0;
          ts16_zeros <= 8'h00;
          ts16_all_zero <= 1'b1;
          ts16_aligned <= 1'b0;
        end else begin
          ts16_frame <= frame_now + 4'd1;
          ts16_zeros <= next_zeros;
          ts16_all_zero <= (mf_start | ts16_all_zero) & (ts16_byte == 8'h00);
          ts16_aligned <= mf_start | ts16_aligned;
        end
      end
    end
  end

  logic [7:0] e1_set;
  logic [7:0] e1_flags;

  always_comb begin
    e1_set = 8'h00;
    if (e1_mode) begin
      e1_set[E1_ALIGN_FRAME] = align_frame_event;
      e1_set[E1_CRC_MF] = crc_mf_boundary;
      e1_set[E1_SIG_ALL_ZEROS] = sa0_evt;
      e1_set[E1_SIG_ALL_ONES] = sa1_evt;
      e1_set[E1_FAS_RESYNC] = fas_evt;
      e1_set[E1_MFA_RESYNC] = mfa_evt;
      e1_set[E1_CRC_RESYNC] = crc_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared offset: a clear reaches the bank of the current mode
  logic event_wr;
  logic [7:0] t1_clr;
  logic [7:0] e1_clr;

  assign event_wr = reg_wr && reg_addr == ADDR_EVENT;
  assign t1_clr = (event_wr && !e1_mode) ? reg_wdata : 8'h00;
  assign e1_clr = (event_wr && e1_mode) ? reg_wdata : 8'h00;

  flag_latch #(.WIDTH(8)) u_t1_flags (
    .mclk (mclk),
    .nrst (nrst),
    .set_evt (t1_set),
    .clr_mask (t1_clr),
    .flags (t1_flags)
  );

  flag_latch #(.WIDTH(8)) u_e1_flags (
    .mclk (mclk),
    .nrst (nrst),
    .set_evt (e1_set),
    .clr_mask (e1_clr),
    .flags (e1_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pending request to the chip interrupt logic; t1 events never count
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      status_event_pending <= 1'b0;
    end else begin
      status_event_pending <= (|alarm_flags) |
        (e1_mode & |(e1_flags & E1_PENDING_MASK));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SPARE_LEN: reg_rdata <= {5'h00, spare_code_length_sel};
        ADDR_TP_CTRL: reg_rdata <= {5'h00, tp_ctrl};
        ADDR_TP_SUPPRESS: reg_rdata <= channel_bit_suppress;
        ADDR_ALARM: reg_rdata <= alarm_flags;
        ADDR_EVENT: reg_rdata <= e1_mode ? e1_flags : t1_flags;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : rx_alarm_port

// *** dv/rx_alarm_port_monitor.sv ***
/*
  Port checker for rx_alarm_port.
  Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module rx_alarm_port_monitor
  import rx_status_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // framer side
  input wire logic e1_mode,
  input wire logic remote_alarm,
  input wire logic frame_sync_lost,
  input wire logic align_frame_event,
  input wire logic framer_bit,
  input wire logic framer_bit_valid,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic f_bit_slot,
  input wire logic [2:0] chan_bit_index,
  // outputs
  input wire logic bert_bit,
  input wire logic bert_bit_valid,
  input wire logic [3:0] spare_len_bits,
  input wire logic spare_len_ext,
  input wire logic status_event_pending
);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the routing registers, as software wrote them
  logic [2:0] ct;
  logic [7:0] sp;
  wire logic [2:0] w3 = reg_wdata[2:0];
  // the F-bit slot is no channel bit, so suppress never applies there
  wire logic drop = (sp[chan_bit_index] & !f_bit_slot) |
    (!e1_mode & !ct[1] & f_bit_slot);
  wire logic src_ok = ct[2] ? tx_bit_valid : framer_bit_valid;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ct <= 3'h0;
      sp <= 8'h00;
    end else if (reg_wr && reg_addr == ADDR_TP_CTRL) begin
      ct <= reg_wdata[2:0];
    end else if (reg_wr && reg_addr == ADDR_TP_SUPPRESS) begin
      sp <= reg_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_e1_evt;
    align_frame_event && e1_mode ##1 e1_mode[*2];
  endsequence
  a_spare_map: assert property (reg_wr && reg_addr == ADDR_SPARE_LEN |-> ##2
    spare_len_bits == {1'b0, $past(w3, 2)} + 4'h1 &&
    spare_len_ext == ($past(w3, 2) == 3'h7)) else $error("spare length");
  a_dir_line: assert property (ct[0] && !ct[2] && src_ok && !drop |=>
    bert_bit_valid && bert_bit == $past(framer_bit)) else $error("line src");
  a_dir_sys: assert property (ct[0] && ct[2] && src_ok && !drop |=>
    bert_bit_valid && bert_bit == $past(tx_bit)) else $error("tx src");
  a_port_idle: assert property (!(ct[0] && src_ok) |=> !bert_bit_valid)
    else $error("tester port active");
  a_bit_drop: assert property (drop |=> !bert_bit_valid)
    else $error("dropped bit passed");
  a_lof_rise: assert property ($rose(frame_sync_lost) |-> ##2
    status_event_pending) else $error("frame loss no request");
  a_ra_fall: assert property ($fell(remote_alarm) |-> ##2
    status_event_pending) else $error("remote clear no request");
  a_e1_irq: assert property (s_e1_evt |-> ##[1:2] status_event_pending)
    else $error("e1 event no request");
endmodule : rx_alarm_port_monitor

bind rx_alarm_port rx_alarm_port_monitor mon (.*);

// *** dv/line_partner.sv ***
/*
  Line receiver stand-in: AMI symbols and a symbol tick.
  Assumes the tick is only wanted while en is high.
*/
`timescale 1ns/1ps
module line_partner (
  input wire logic mclk,
  input wire logic en,
  input wire logic ones,
  output logic pos,
  output logic neg,
  output logic tick
);
  logic [1:0] ph = 2'h0;
  logic pol = 1'b0;
  initial {pos, neg, tick} = 3'h0;
  // tick lags the pins by 3 cycles so the 2-stage sync has settled
  always @(posedge mclk) begin
    tick <= en && ph == 2'h3;
    ph <= ph + 2'h1;
    if (en && ph == 2'h0) begin
      pos <= ones && !pol;
      neg <= ones && pol;
      pol <= pol ^ ones;
    end
  end
endmodule : line_partner

// *** dv/tb_top.sv ***
/*
  Self-checking bench for rx_alarm_port with a register model.
  Assumes the bound port checker and the line partner.
*/
`timescale 1ns/1ps
module tb_top
  import rx_status_pkg::*;
;
  logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic e1_mode = 1'b0, lp_en = 1'b0, lp_ones = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ts16_byte;
  logic remote_alarm, frame_sync_lost, resync_done, framing_bit_strobe;
  logic framing_bit_err, crc_word_strobe, crc_word_err, mfa_word_strobe;
  logic mfa_word_err, fas_word_strobe, fas_word_err, ts16_strobe, mf_start;
  logic crc_mf_boundary, align_frame_event, framer_bit, framer_bit_valid;
  logic tx_bit, tx_bit_valid, f_bit_slot, bert_bit, bert_bit_valid;
  logic line_in_pos, line_in_neg, line_bit_tick, spare_len_ext;
  logic status_event_pending;
  logic [3:0] resync_alignment, spare_len_bits;
  logic [2:0] chan_bit_index;
  logic [7:0] m [0:255] = '{default: 8'h00};
  logic [31:0] r = 32'h8FE54F33;
  int n_fail = 0, cmp_count = 0, i;

  rx_alarm_port uut (.*);
  line_partner lp (.mclk(mclk), .en(lp_en), .ones(lp_ones),
    .pos(line_in_pos), .neg(line_in_neg), .tick(line_bit_tick));
  always #20 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic drive(input logic [34:0] v);
    {crc_word_strobe, crc_word_err, mfa_word_strobe, mfa_word_err,
      fas_word_strobe, fas_word_err, ts16_strobe, mf_start, crc_mf_boundary,
      align_frame_event, ts16_byte, remote_alarm, frame_sync_lost,
      resync_done, resync_alignment, framing_bit_strobe, framing_bit_err,
      framer_bit, framer_bit_valid, tx_bit, tx_bit_valid, f_bit_slot,
      chan_bit_index} <= v;
  endtask : drive
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_wr <= 1'b0;
    // model: rw fields masked, flag bytes write-one-to-clear
    if (a == ADDR_TP_SUPPRESS) m[a] = d;
    else if (a[7:4] == 4'h8) m[a] = d & 8'h07;
    else m[a] = m[a] & ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk8(reg_rdata, m[a]);
  endtask : rd
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #2000000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    drive('0);
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    foreach (m[j]) if (j >= 8'h89 && j <= 8'h92) rd(8'(j));
    for (i = 0; i < 8; i++) begin
      wr(ADDR_SPARE_LEN, 8'hF8 | 8'(i));
      rd(ADDR_SPARE_LEN);
    end
    for (i = 0; i < 8; i++) begin
      r = lfsr(r);
      wr(ADDR_TP_CTRL, r[7:0]);
      wr(ADDR_TP_SUPPRESS, r[15:8] & r[23:16]);
      rd(ADDR_TP_CTRL);
      rd(ADDR_TP_SUPPRESS);
      repeat (40) begin
        @(posedge mclk);
        r = lfsr(r);
        drive({18'h0, r[16:0]});
      end
    end
    drive('0);
    repeat (4) @(posedge mclk);
    wr(ADDR_ALARM, 8'hFF);
    wr(ADDR_EVENT, 8'hFF);
    wr(8'h92, 8'hFF);
    rd(8'h92);
    rd(ADDR_ALARM);
    @(posedge mclk);
    frame_sync_lost <= 1'b1;
    remote_alarm <= 1'b1;
    repeat (3) @(posedge mclk);
    m[ADDR_ALARM] = 8'h09;
    rd(ADDR_ALARM);
    // clear while high, so the fall alone must raise the request again
    wr(ADDR_ALARM, 8'hFF);
    drive('0);
    repeat (3) @(posedge mclk);
    m[ADDR_ALARM] = 8'h90;
    rd(ADDR_ALARM);
    wr(ADDR_ALARM, 8'h10);
    rd(ADDR_ALARM);
    wr(ADDR_ALARM, 8'hFF);
    {lp_en, lp_ones} <= 2'b10;
    repeat (820) @(posedge mclk);
    lp_ones <= 1'b1;
    repeat (8300) @(posedge mclk);
    lp_en <= 1'b0;
    m[ADDR_ALARM] = 8'h26;
    m[ADDR_EVENT] = 8'h98;
    rd(ADDR_ALARM);
    rd(ADDR_EVENT);
    wr(ADDR_EVENT, 8'hFF);
    // alarm flags off, so only e1 events can hold the request up
    wr(ADDR_ALARM, 8'hFF);
    e1_mode <= 1'b1;
    for (i = 0; i < 1000; i++) begin
      @(posedge mclk);
      {crc_word_strobe, crc_word_err} <= {1'b1, i < 915};
      {fas_word_strobe, fas_word_err} <= {i < 3, 1'b1};
      {mfa_word_strobe, mfa_word_err} <= {i < 2, 1'b1};
      ts16_strobe <= i < 32;
      ts16_byte <= i < 16 ? 8'hFF : 8'h00;
      mf_start <= i == 0 || i == 16;
      {align_frame_event, crc_mf_boundary} <= {2{i == 0}};
      @(posedge mclk);
      drive('0);
    end
    repeat (5) @(posedge mclk);
    m[ADDR_EVENT] = 8'h7F;
    rd(ADDR_EVENT);
    wr(ADDR_EVENT, 8'h0F);
    rd(ADDR_EVENT);
    tally_and_finish();
  end
endmodule : tb_top
